// File: srff_top.sv
// clocked set-reset flip-flop with three-valued state and async force inputs
`timescale 1ns/1ps

// Functional notes
// - state changes at rising clock edge, or at once on a force input
// - hold, clear to 0, set to 1
// - set and clear both high gives unknown
// - set low, clear unknown: keeps only 0
// - set unknown, clear low: keeps only 1
// - other unknown request mixes give unknown
module srff_top
  import srff_pkg::*;
#(
  parameter logic [1:0] RST_CODE = SRFF_RST_CODE
)
(
  // clock and synchronous reset
  // reset is sampled like any other input at the rising edge
  input wire logic mclk,
  input wire logic sys_rst,
  // set request and its unknown flag
  input wire logic set_req,
  input wire logic set_unk,
  // clear request and its unknown flag
  input wire logic clr_req,
  input wire logic clr_unk,
  // asynchronous force inputs, active high
  // they act at once and dominate the synchronous reset
  input wire logic force_set,
  input wire logic force_clr,
  // outputs
  output logic q,
  output logic q_n,
  output logic q_unk
);

  // registered state and its next value
  // the struct keeps level and outputs together in one register
  srff_st_t st_r;
  srff_st_t st_nxt;

  // request levels as seen at this edge
  srff_lvl_t set_lvl;
  srff_lvl_t clr_lvl;

  // level chosen by the table
  // (ignored while reset or a force is active)
  srff_lvl_t tbl_lvl;

  // decode the request pins; an unknown flag overrides the value bit
  // so that a floating value bit never reads as a firm request
  assign set_lvl = srff_in_lvl(set_req, set_unk);
  assign clr_lvl = srff_in_lvl(clr_req, clr_unk);

  // next-level table; kept in its own module so the three-valued rules
  // read as one list, apart from reset and force handling
  srff_next srff_next_inst (
    .set_lvl(set_lvl),
    .clr_lvl(clr_lvl),
    .old_lvl(st_r.lvl),
    .new_lvl(tbl_lvl)
  );

  // next state: the table by default, synchronous reset on top of it;
  // the outputs are rebuilt from the level each cycle, so q, q_n and
  // q_unk can never disagree with one another
  always_comb begin
    st_nxt = srff_mk_st(tbl_lvl);
    if (sys_rst) begin
      st_nxt = srff_mk_st(srff_code_lvl(RST_CODE));
    end
  end

  // single state register; force inputs act without the clock and
  // load constants only; both forces together leave the level unknown
  // rather than letting one side win silently
  // limitation: if one force drops while the other stays high, the level
  // stays unknown until the next clock edge, where the remaining force wins
  always_ff @(posedge mclk or posedge force_set or posedge force_clr) begin
    if (force_set && force_clr) begin
      // both forces: neither side wins
      st_r <= '{lvl: LVL_UNK, q: 1'b0, q_n: 1'b1, q_unk: 1'b1};
    end else if (force_set) begin
      // force set: stored high at once
      st_r <= '{lvl: LVL_HI, q: 1'b1, q_n: 1'b0, q_unk: 1'b0};
    end else if (force_clr) begin
      // force clear: stored low at once
      st_r <= '{lvl: LVL_LO, q: 1'b0, q_n: 1'b1, q_unk: 1'b0};
    end else begin
      // clock edge: reset or table result
      st_r <= st_nxt;
    end
  end

  // outputs come straight from the state register; unknown is encoded, not
  // driven as X, so downstream logic sees q low and q_n high with q_unk set
  assign q = st_r.q;
  assign q_n = st_r.q_n;
  assign q_unk = st_r.q_unk;

  // checks on the table, taken only while no force is active; each samples
  // the request levels at one edge and the outputs or the stored level at the next

  // both requests low: the stored level must not move
  a_hold_idle: assert property (@(posedge mclk)
    disable iff (sys_rst || force_set || force_clr)
    (set_lvl == LVL_LO && clr_lvl == LVL_LO) |=> $stable(st_r.lvl))
    else $error("state moved with both requests low");

  // clear alone loads zero, whatever was stored before
  a_clear_loads_zero: assert property (@(posedge mclk)
    disable iff (sys_rst || force_set || force_clr)
    (set_lvl == LVL_LO && clr_lvl == LVL_HI) |=> (!q && q_n && !q_unk))
    else $error("clear request did not load zero");

  // set alone loads one, whatever was stored before
  a_set_loads_one: assert property (@(posedge mclk)
    disable iff (sys_rst || force_set || force_clr)
    (set_lvl == LVL_HI && clr_lvl == LVL_LO) |=> (q && !q_n && !q_unk))
    else $error("set request did not load one");

  // a firm set must also recover a stored unknown
  a_set_from_unk: assert property (@(posedge mclk)
    disable iff (sys_rst || force_set || force_clr)
    (set_lvl == LVL_HI && clr_lvl == LVL_LO && st_r.lvl == LVL_UNK) |=> (q && !q_unk))
    else $error("set request did not recover an unknown level");

  // a firm clear must also recover a stored unknown
  a_clear_from_unk: assert property (@(posedge mclk)
    disable iff (sys_rst || force_set || force_clr)
    (set_lvl == LVL_LO && clr_lvl == LVL_HI && st_r.lvl == LVL_UNK) |=> (!q && !q_unk))
    else $error("clear request did not recover an unknown level");

  // both firm requests high: unknown, never a toggle (seen on the raw pins)
  a_both_high_unk: assert property (@(posedge mclk)
    disable iff (sys_rst || force_set || force_clr)
    (set_req && !set_unk && clr_req && !clr_unk) |=> q_unk)
    else $error("both requests high did not give unknown");

  // the same case on the stored level; an old high must not turn into a low
  a_both_high_level: assert property (@(posedge mclk)
    disable iff (sys_rst || force_set || force_clr)
    (set_lvl == LVL_HI && clr_lvl == LVL_HI) |=> (st_r.lvl == LVL_UNK && !q && q_n))
    else $error("both requests high did not store unknown");

  // unknown clear: a stored low survives and stays low, else unknown
  a_clr_unk_keeps: assert property (@(posedge mclk)
    disable iff (sys_rst || force_set || force_clr)
    (set_lvl == LVL_LO && clr_lvl == LVL_UNK)
    |=> (q_unk == ($past(st_r.lvl) != LVL_LO)) && (q_unk || !q))
    else $error("unknown clear handled wrongly");

  // unknown set: a stored high survives and stays high, else unknown
  a_set_unk_keeps: assert property (@(posedge mclk)
    disable iff (sys_rst || force_set || force_clr)
    (set_lvl == LVL_UNK && clr_lvl == LVL_LO)
    |=> (q_unk == ($past(st_r.lvl) != LVL_HI)) && (q_unk || q))
    else $error("unknown set handled wrongly");

  // every other mix with an unknown request ends unknown, no matter
  // what was stored, because no firm result is assured
  a_mixed_unk: assert property (@(posedge mclk)
    disable iff (sys_rst || force_set || force_clr)
    ((set_lvl == LVL_HI && clr_lvl == LVL_UNK) ||
     (set_lvl == LVL_UNK && clr_lvl == LVL_HI) ||
     (set_lvl == LVL_UNK && clr_lvl == LVL_UNK)) |=> q_unk)
    else $error("mixed unknown requests did not give unknown");

  // the three outputs agree once reset has loaded the state; before the
  // first reset edge the register is still empty, so reset masks the check
  a_outputs_inverse: assert property (@(posedge mclk)
    disable iff (sys_rst)
    (q_n == !q) && (q_unk == (st_r.lvl == LVL_UNK)))
    else $error("complementary output not inverse");

  // a held force set overrides every clock edge
  a_force_set_one: assert property (@(posedge mclk)
    (force_set && !force_clr) |-> (q && !q_unk))
    else $error("force set did not hold output high");

  // a held force clear overrides every clock edge
  a_force_clr_zero: assert property (@(posedge mclk)
    (force_clr && !force_set) |-> (!q && !q_unk))
    else $error("force clear did not hold output low");

  // both forces together leave the encoded unknown
  a_force_both_unk: assert property (@(posedge mclk)
    (force_set && force_clr) |-> (q_unk && !q && q_n))
    else $error("both forces did not give unknown");

  // the register takes the prepared next state at the edge and nothing else
  a_edge_only: assert property (@(posedge mclk)
    disable iff (sys_rst || force_set || force_clr)
    ##1 (st_r.lvl == $past(st_nxt.lvl)))
    else $error("state differs from value loaded at the edge");

  // synchronous reset lands the coded level at the next edge; only a
  // force may override it, so the force inputs alone mask this check
  a_reset_loads_code: assert property (@(posedge mclk)
    disable iff (force_set || force_clr)
    sys_rst |=> (st_r.lvl == srff_code_lvl(RST_CODE)))
    else $error("synchronous reset did not load its level");

  // main scenarios
  // set then clear on consecutive edges
  c_set_then_clear: cover property (@(posedge mclk) disable iff (sys_rst)
    (set_lvl == LVL_HI && clr_lvl == LVL_LO) ##1 (set_lvl == LVL_LO && clr_lvl == LVL_HI));
  // an unknown level recovered by a firm set
  c_unk_recovered: cover property (@(posedge mclk) disable iff (sys_rst)
    q_unk ##1 (set_lvl == LVL_HI && clr_lvl == LVL_LO) ##1 q);
  // a stored low surviving an unknown clear
  c_clr_unk_keeps_low: cover property (@(posedge mclk) disable iff (sys_rst)
    (!q && !q_unk && set_lvl == LVL_LO && clr_lvl == LVL_UNK) ##1 (!q && !q_unk));
  // both firm requests giving unknown
  c_both_high_unk: cover property (@(posedge mclk) disable iff (sys_rst)
    (set_lvl == LVL_HI && clr_lvl == LVL_HI) ##1 q_unk);
  // a force set pulse
  c_force_set: cover property (@(posedge mclk) force_set ##1 !force_set);

endmodule

// File: srff_pkg.sv
// shared types, reset values and helpers of the set-reset flip-flop
package srff_pkg;

  // three-valued level carried by the stored state and by each request
  typedef enum logic [1:0] {
    LVL_LO,
    LVL_HI,
    LVL_UNK
  } srff_lvl_t;

  // whole registered state of the flip-flop
  typedef struct packed {
    srff_lvl_t lvl;   // stored level
    logic q;          // true output
    logic q_n;        // complementary output
    logic q_unk;      // stored level is unknown
  } srff_st_t;

  // level after synchronous reset (0 = low, 1 = high, 2 = unknown)
  localparam logic [1:0] SRFF_RST_CODE = 2'h0;

  // map a request pin pair onto a level; the unknown flag dominates
  function automatic srff_lvl_t srff_in_lvl(input logic req, input logic unk);
    srff_lvl_t l;
    l = LVL_LO;
    if (unk) begin
      l = LVL_UNK;
    end else if (req) begin
      l = LVL_HI;
    end
    return l;
  endfunction

  // map a reset code onto a level
  function automatic srff_lvl_t srff_code_lvl(input logic [1:0] code);
    srff_lvl_t l;
    l = LVL_UNK;
    if (code == 2'h0) begin
      l = LVL_LO;
    end else if (code == 2'h1) begin
      l = LVL_HI;
    end
    return l;
  endfunction

  // build a full state from a level; unknown shows q low, q_n high
  function automatic srff_st_t srff_mk_st(input srff_lvl_t l);
    srff_st_t s;
    s.lvl = l;
    s.q = (l == LVL_HI);
    s.q_n = ~(l == LVL_HI);
    s.q_unk = (l == LVL_UNK);
    return s;
  endfunction

endpackage

// File: srff_next.sv
// next-level table of the set-reset flip-flop, three-valued
`timescale 1ns/1ps

module srff_next
  import srff_pkg::*;
(
  // request levels
  input srff_lvl_t set_lvl,
  input srff_lvl_t clr_lvl,
  // level held now
  input srff_lvl_t old_lvl,
  // level to load at the next edge
  output srff_lvl_t new_lvl
);

  // one combinational table; any case not listed resolves to unknown
  always_comb begin
    new_lvl = LVL_UNK;
    case ({set_lvl, clr_lvl})
      {LVL_LO, LVL_LO}: begin
        new_lvl = old_lvl;
      end
      {LVL_LO, LVL_HI}: begin
        new_lvl = LVL_LO;
      end
      {LVL_HI, LVL_LO}: begin
        new_lvl = LVL_HI;
      end
      {LVL_HI, LVL_HI}: begin
        new_lvl = LVL_UNK;
      end
      {LVL_LO, LVL_UNK}: begin
        // a pending clear can only pull low, so a held low survives
        new_lvl = (old_lvl == LVL_LO) ? LVL_LO : LVL_UNK;
      end
      {LVL_UNK, LVL_LO}: begin
        // a pending set can only pull high, so a held high survives
        new_lvl = (old_lvl == LVL_HI) ? LVL_HI : LVL_UNK;
      end
      default: begin
        new_lvl = LVL_UNK;
      end
    endcase
  end

endmodule

// File: srff_req_src.sv
// request source model: drives the set and clear request pins from level codes
`timescale 1ns/1ps

module srff_req_src
  import srff_pkg::*;
(
  // clock
  input wire logic mclk,
  // requested levels
  input wire srff_lvl_t set_lvl,
  input wire srff_lvl_t clr_lvl,
  // request pins
  output logic set_req,
  output logic set_unk,
  output logic clr_req,
  output logic clr_unk
);
  logic junk_r = 1'b0; // value bit shown under an unknown request

  // flip on the falling edge, so a stale value bit never passes for a real one
  always_ff @(negedge mclk) begin
    junk_r <= ~junk_r;
  end

  // unknown flag raised; the value bit then carries junk on purpose
  assign set_unk = (set_lvl == LVL_UNK);
  assign clr_unk = (clr_lvl == LVL_UNK);
  assign set_req = set_unk ? junk_r : (set_lvl == LVL_HI);
  assign clr_req = clr_unk ? ~junk_r : (clr_lvl == LVL_HI);
endmodule

// File: srff_top_test.sv
// self-checking bench of the set-reset flip-flop
`timescale 1ns/1ps

module srff_top_test;
  import srff_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, force_set = 1'b0, force_clr = 1'b0;
  srff_lvl_t set_lvl = LVL_LO, clr_lvl = LVL_LO, exp_lvl = LVL_LO; // drive and model state
  logic set_req, set_unk, clr_req, clr_unk, q, q_n, q_unk;
  srff_lvl_t notes[$]; // expected levels, oldest first
  srff_lvl_t held = LVL_LO; // level checked at the last rising edge
  logic held_ok = 1'b0; // a level has been checked at least once
  int num_errors = 0, comparisons = 0;

  // 125 MHz clock
  initial forever #4 mclk = ~mclk;

  srff_req_src srff_req_src_inst (.mclk(mclk), .set_lvl(set_lvl), .clr_lvl(clr_lvl),
    .set_req(set_req), .set_unk(set_unk), .clr_req(clr_req), .clr_unk(clr_unk));
  srff_top srff_top_inst (.mclk(mclk), .sys_rst(sys_rst), .set_req(set_req),
    .set_unk(set_unk), .clr_req(clr_req), .clr_unk(clr_unk), .force_set(force_set),
    .force_clr(force_clr), .q(q), .q_n(q_n), .q_unk(q_unk));

  // reference next level; unknown wins wherever a known result is not assured
  function automatic srff_lvl_t tbl(srff_lvl_t s, srff_lvl_t r, srff_lvl_t o);
    if (s == LVL_LO && r == LVL_LO) return o;
    if (s == LVL_LO && r == LVL_HI) return LVL_LO;
    if (s == LVL_HI && r == LVL_LO) return LVL_HI;
    if (s == LVL_LO && r == LVL_UNK && o == LVL_LO) return LVL_LO;
    if (s == LVL_UNK && r == LVL_LO && o == LVL_HI) return LVL_HI;
    return LVL_UNK;
  endfunction

  // one request pair per cycle, launched at the falling edge
  task automatic step(input srff_lvl_t s, input srff_lvl_t r);
    @(negedge mclk);
    set_lvl = s;
    clr_lvl = r;
    exp_lvl = tbl(s, r, exp_lvl);
    notes.push_back(exp_lvl);
  endtask

  // set the force pins and note the level they impose
  task automatic frc(input logic fs, input logic fc, input srff_lvl_t e);
    @(negedge mclk);
    force_set = fs;
    force_clr = fc;
    exp_lvl = e;
    notes.push_back(e);
  endtask

  task automatic check(input srff_lvl_t e);
    logic [2:0] want;
    want = (e == LVL_UNK) ? 3'h5 : ((e == LVL_HI) ? 3'h2 : 3'h1);
    comparisons++;
    if ({q_unk, q, q_n} !== want) begin
      num_errors++;
      $display("wrong value q_unk_q_qn expected %b seen %b", want, {q_unk, q, q_n});
    end
  endtask

  // monitor: results settle just after the rising edge
  always @(posedge mclk) begin
    #1;
    if (notes.size() > 0) begin
      held = notes.pop_front();
      held_ok = 1'b1;
      check(held);
    end
  end

  // mid-cycle: new requests have just arrived, the outputs must not follow yet
  always @(negedge mclk) begin
    #1;
    if (held_ok && !force_set && !force_clr) check(held);
  end

  task automatic end_sim;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    end_sim;
  end

  initial begin
    void'($urandom(32'h273F));
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    notes.push_back(exp_lvl); // first edge out of reset shows the reset level
    step(LVL_LO, LVL_LO);
    // every old level against every request pair, back to back
    for (int o = 0; o < 3; o++) begin
      for (int s = 0; s < 3; s++) begin
        for (int r = 0; r < 3; r++) begin
          step((o == 0) ? LVL_LO : LVL_HI, (o == 1) ? LVL_LO : LVL_HI);
          step(srff_lvl_t'(s), srff_lvl_t'(r));
        end
      end
    end
    repeat (60) step(srff_lvl_t'($urandom % 3), srff_lvl_t'($urandom % 3));
    step(LVL_LO, LVL_LO);
    frc(1'b1, 1'b0, LVL_HI);
    frc(1'b0, 1'b0, LVL_HI);
    frc(1'b0, 1'b1, LVL_LO);
    frc(1'b0, 1'b0, LVL_LO);
    frc(1'b1, 1'b1, LVL_UNK);
    frc(1'b0, 1'b0, LVL_UNK);
    step(LVL_HI, LVL_LO);
    step(LVL_LO, LVL_LO);
    // reset in mid-run, overridden by a force and then taking over again
    @(negedge mclk);
    sys_rst = 1'b1;
    exp_lvl = LVL_LO;
    notes.push_back(exp_lvl);
    frc(1'b1, 1'b0, LVL_HI);
    frc(1'b0, 1'b0, LVL_LO);
    step(LVL_LO, LVL_LO);
    sys_rst = 1'b0;
    step(LVL_HI, LVL_LO);
    repeat (2) @(negedge mclk);
    if (notes.size() != 0) begin
      num_errors++;
      $display("wrong value notes_left expected 0 seen %0d", notes.size());
    end
    end_sim;
  end
endmodule
